// ---- design/esam_defines.vh ----
// offsets, field positions, reset values and codes for the error action block
`ifndef ESAM_DEFINES_VH
`define ESAM_DEFINES_VH
`define ESAM_STAT_W 24
`define ESAM_OFF_AUX_MASK 4'h0
`define ESAM_OFF_FRZ_MASK 4'h1
`define ESAM_OFF_T1_MASK 4'h2
`define ESAM_OFF_T1_MODE 4'h3
`define ESAM_OFF_T1_RATE 4'h4
`define ESAM_OFF_STATUS 4'h5
`define ESAM_OFF_IRQ_STAT 4'h6
`define ESAM_OFF_IRQ_EN 4'h7
`define ESAM_OFF_IRQ_CLR 4'h8
`define ESAM_OFF_ACTIONS 4'h9
`define ESAM_RST_AUX 24'h000000
`define ESAM_RST_FRZ 24'h000008
`define ESAM_RST_T1 24'h019B01
`define ESAM_RST_MODE 2'h0
`define ESAM_RST_RATE 16'h0000
`define ESAM_RESERVED 24'hC00400
`define ESAM_MODE_NONE 2'h0
`define ESAM_MODE_HOLD 2'h1
`define ESAM_MODE_EXIT 2'h2
`define ESAM_BIT_TRAVEL_LO 6
`define ESAM_BIT_TRAVEL_HI 9
`define ESAM_IRQ_AUX 0
`define ESAM_IRQ_FRZ 1
`define ESAM_IRQ_HOLD 2
`define ESAM_IRQ_EXIT 3
`define ESAM_IRQ_W 4
`endif

// ---- design/esam_mask_hit.v ----
// one mask action: or over status and mask with reserved positions removed
`include "esam_defines.vh"
module esam_mask_hit #(
  parameter W = 24
) (
  input wire [W-1:0] status,
  input wire [W-1:0] mask,
  output wire hit
);
  wire [W-1:0] keep = ~`ESAM_RESERVED;
  assign hit = |(status & mask & keep);
endmodule

// ---- design/esam_top.v ----
// error status action masks with avalon register slave
`include "esam_defines.vh"
// Behaviour
// - The auxiliary pin is active while any non-reserved status bit enabled in the auxiliary mask is set.
// - A mask bit of one enables its action for the matching status bit, e.g. bits 6 to 9 for all travel limits.
// - The auxiliary mask resets to zero.
// - A freeze-selected active condition stops position command updates at once, holding the command.
// - The freeze mask resets to 0x8, selecting status bit 3.
// - Task-one mode two with a selected active condition stops and exits the task-one program.
// - Task-one mode one with a selected active condition feedholds task one at the programmed rate.
// - Task-one mode zero takes no task-one exception action.
// - The task-one mask resets to 0x019B01.
// - Masks are 24 bits matching the status word, with bits 10, 22 and 23 reserved.
// - Bits 6 and 7 are software travel limits and bits 8 and 9 hardware travel limits.
// - Bits 12 to 21 are the traps, user traps, task runtime errors and calibration error.
module esam_top #(
  parameter W = 24,
  parameter RATE_W = 16,
  parameter POS_W = 32
) (
  input wire clk,
  input wire rst_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [W-1:0] err_status,
  input wire [POS_W-1:0] traj_pos_cmd,
  output reg [POS_W-1:0] pos_cmd_q,
  output reg aux_out_q,
  output reg freeze_q,
  output reg t1_hold_q,
  output reg t1_exit_q,
  output reg [RATE_W-1:0] t1_hold_rate_q,
  output reg irq_q
);
  reg [W-1:0] aux_mask_q;
  reg [W-1:0] frz_mask_q;
  reg [W-1:0] t1_mask_q;
  reg [1:0] t1_mode_q;
  reg [`ESAM_IRQ_W-1:0] irq_stat_q;
  reg [`ESAM_IRQ_W-1:0] irq_en_q;
  reg [`ESAM_IRQ_W-1:0] irq_stat_d;
  reg [`ESAM_IRQ_W-1:0] prev_q;
  reg ack_q;
  wire aux_hit;
  wire frz_hit;
  wire t1_hit;
  wire t1_hold_d;
  wire t1_exit_d;
  wire [`ESAM_IRQ_W-1:0] events;
  wire acc = (avs_read | avs_write) & ~ack_q;
  // writes commit on the edge the master sees waitrequest low
  wire wr = avs_write & ack_q;

  // byte-lane merge of write data onto a register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // merged write words, cut back to register width on purpose
  wire [31:0] aux_mrg = merge({{(32-W){1'b0}}, aux_mask_q}, avs_writedata,
    avs_byteenable);
  wire [31:0] frz_mrg = merge({{(32-W){1'b0}}, frz_mask_q}, avs_writedata,
    avs_byteenable);
  wire [31:0] t1_mrg = merge({{(32-W){1'b0}}, t1_mask_q}, avs_writedata,
    avs_byteenable);
  wire [31:0] rate_mrg = merge({{(32-RATE_W){1'b0}}, t1_hold_rate_q},
    avs_writedata, avs_byteenable);

  // status bit layout travels straight through; bits 6..9 travel limits,
  // 12..21 traps and task errors, 10/22/23 reserved
  esam_mask_hit #(.W(W)) u_aux (
    .status(err_status),
    .mask(aux_mask_q),
    .hit(aux_hit)
  );
  esam_mask_hit #(.W(W)) u_frz (
    .status(err_status),
    .mask(frz_mask_q),
    .hit(frz_hit)
  );
  esam_mask_hit #(.W(W)) u_t1 (
    .status(err_status),
    .mask(t1_mask_q),
    .hit(t1_hit)
  );

  assign t1_hold_d = t1_hit & (t1_mode_q == `ESAM_MODE_HOLD);
  assign t1_exit_d = t1_hit & (t1_mode_q == `ESAM_MODE_EXIT);
  assign events = {t1_exit_d, t1_hold_d, frz_hit, aux_hit} & ~prev_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_out_q <= 1'b0;
      freeze_q <= 1'b0;
      t1_hold_q <= 1'b0;
      t1_exit_q <= 1'b0;
      prev_q <= {`ESAM_IRQ_W{1'b0}};
      pos_cmd_q <= {POS_W{1'b0}};
    end else begin
      aux_out_q <= aux_hit;
      freeze_q <= frz_hit;
      t1_hold_q <= t1_hold_d;
      t1_exit_q <= t1_exit_d;
      prev_q <= {t1_exit_d, t1_hold_d, frz_hit, aux_hit};
      // combinational hit so the hold starts in the same edge
      if (!frz_hit)
        pos_cmd_q <= traj_pos_cmd;
    end
  end

  // set wins over clear on the same edge
  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr && avs_address == `ESAM_OFF_IRQ_CLR)
      irq_stat_d = irq_stat_d & ~avs_writedata[`ESAM_IRQ_W-1:0];
    irq_stat_d = irq_stat_d | events;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_mask_q <= `ESAM_RST_AUX;
      frz_mask_q <= `ESAM_RST_FRZ;
      t1_mask_q <= `ESAM_RST_T1;
      t1_mode_q <= `ESAM_RST_MODE;
      t1_hold_rate_q <= `ESAM_RST_RATE;
      irq_stat_q <= {`ESAM_IRQ_W{1'b0}};
      irq_en_q <= {`ESAM_IRQ_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_en_q);
      if (wr) begin
        case (avs_address)
          `ESAM_OFF_AUX_MASK: aux_mask_q <= aux_mrg[W-1:0];
          `ESAM_OFF_FRZ_MASK: frz_mask_q <= frz_mrg[W-1:0];
          `ESAM_OFF_T1_MASK: t1_mask_q <= t1_mrg[W-1:0];
          `ESAM_OFF_T1_MODE: if (avs_byteenable[0])
            t1_mode_q <= avs_writedata[1:0];
          `ESAM_OFF_T1_RATE: t1_hold_rate_q <= rate_mrg[RATE_W-1:0];
          `ESAM_OFF_IRQ_EN: if (avs_byteenable[0])
            irq_en_q <= avs_writedata[`ESAM_IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // one wait state: waitrequest drops one cycle after the request rises
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= acc;
      avs_waitrequest <= ~acc;
      if (acc && avs_read) begin
        case (avs_address)
          `ESAM_OFF_AUX_MASK: avs_readdata <= {8'h00, aux_mask_q};
          `ESAM_OFF_FRZ_MASK: avs_readdata <= {8'h00, frz_mask_q};
          `ESAM_OFF_T1_MASK: avs_readdata <= {8'h00, t1_mask_q};
          `ESAM_OFF_T1_MODE: avs_readdata <= {30'h00000000, t1_mode_q};
          `ESAM_OFF_T1_RATE: avs_readdata <= {16'h0000, t1_hold_rate_q};
          `ESAM_OFF_STATUS: avs_readdata <= {8'h00, err_status};
          `ESAM_OFF_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_q};
          `ESAM_OFF_IRQ_EN: avs_readdata <= {28'h0000000, irq_en_q};
          `ESAM_OFF_ACTIONS: avs_readdata <= {28'h0000000, t1_exit_q,
            t1_hold_q, freeze_q, aux_out_q};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ---- tb/esam_asserts.sv ----
// port checker for the error action block
module esam_chk (
  input logic clk,
  input logic rst_b,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic [23:0] err_status,
  input logic [31:0] traj_pos_cmd,
  input logic [31:0] pos_cmd_q,
  input logic aux_out_q,
  input logic freeze_q,
  input logic t1_hold_q,
  input logic t1_exit_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_wrise; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_wrise: assert property (p_wrise) else $error("no bus answer");
  property p_wone; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wone: assert property (p_wone) else $error("answer too long");
  property p_widle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
  a_widle: assert property (p_widle) else $error("answer unasked");
  // reserved positions 10, 22, 23 left out of the quiet test
  property p_quiet; (err_status & 24'h3FFBFF) == 24'h0 |=>
    !aux_out_q && !freeze_q && !t1_hold_q && !t1_exit_q; endproperty
  a_quiet: assert property (p_quiet) else $error("action w/o cause");
  property p_pfol; $past(rst_b) && !freeze_q |->
    pos_cmd_q == $past(traj_pos_cmd); endproperty
  a_pfol: assert property (p_pfol) else $error("command not followed");
  property p_phold; $past(rst_b) && freeze_q |-> $stable(pos_cmd_q); endproperty
  a_phold: assert property (p_phold) else $error("command moved");
  property p_t1x; t1_hold_q |-> !t1_exit_q; endproperty
  a_t1x: assert property (p_t1x) else $error("hold and exit");
  property p_rdup; !avs_waitrequest |-> avs_readdata[31:24] == 8'h00; endproperty
  a_rdup: assert property (p_rdup) else $error("upper byte set");
endmodule

// ---- tb/test_esam_top.sv ----
// self-checking bench for the error action block
module test_esam_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 0, traj_pos_cmd = 0, avs_readdata, pos_cmd_q;
  logic [23:0] err_status = 0;
  logic [15:0] t1_hold_rate_q;
  logic avs_waitrequest, aux_out_q, freeze_q, t1_hold_q, t1_exit_q, irq_q;
  logic [31:0] rd_q;
  int fails = 0, n_tests = 0;
  esam_top uut (.*);
  initial forever #4 clk = ~clk;
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) @(posedge clk);
    rd_q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    // one idle edge so no strobe is set twice in a time step
    @(posedge clk);
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    bus(a, 1'h0, 0);
    chk(rd_q, e);
  endtask
  task step(input logic [23:0] s);
    err_status <= s;
    repeat (3) @(posedge clk);
  endtask
  task t_aux;
    bus(4'h0, 1'h1, 32'h3C0);
    for (int b = 6; b < 10; b++) begin
      step(24'h1 << b);
      chk(aux_out_q, 1'h1);
    end
    step(24'h20);
    chk(aux_out_q, 1'h0);
    bus(4'h0, 1'h1, 32'hFFFFFF);
    step(24'hC00400);
    chk(aux_out_q, 1'h0);
    rdc(4'h0, 32'hFFFFFF);
  endtask
  task t_frz;
    traj_pos_cmd <= 32'h1234;
    step(24'h0);
    traj_pos_cmd <= 32'h5678;
    step(24'h8);
    chk(freeze_q, 1'h1);
    chk(pos_cmd_q, 32'h1234);
    step(24'h0);
    chk(pos_cmd_q, 32'h5678);
  endtask
  task t_mode;
    bus(4'h4, 1'h1, 32'hBEEF);
    chk(t1_hold_rate_q, 32'hBEEF);
    for (int m = 0; m < 4; m++) begin
      bus(4'h3, 1'h1, m);
      step(24'h1000);
      chk({t1_exit_q, t1_hold_q}, m == 3 ? 0 : m);
    end
    rdc(4'h5, 32'h1000);
    rdc(4'h9, 32'h1);
  endtask
  task t_irq;
    step(24'h0);
    bus(4'h8, 1'h1, 32'hF);
    rdc(4'h6, 32'h0);
    bus(4'h7, 1'h1, 32'h1);
    step(24'h40);
    rdc(4'h6, 32'h1);
    chk(irq_q, 1'h1);
    bus(4'h8, 1'h1, 32'hF);
    bus(4'h7, 1'h1, 32'h0);
    step(24'h0);
    step(24'h40);
    chk(irq_q, 1'h0);
    rdc(4'h6, 32'h1);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rdc(4'h0, 32'h0);
    rdc(4'h1, 32'h8);
    rdc(4'h2, 32'h19B01);
    rdc(4'hF, 32'h0);
    t_aux;
    t_frz;
    t_mode;
    t_irq;
    report_and_stop;
  end
  initial begin
    #20us;
    fails++;
    report_and_stop;
  end
endmodule
bind esam_top esam_chk u_chk (.*);
